// [include/timebase_pkg.sv]
// ==========================================================================
// Shared constants for the time-base free-running counter
package timebase_pkg;

	// ======================================================================
	// Register map (printed offsets are word indices)
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] FLAG_INDEX = 8'h01;
	localparam logic [ADDR_W-1:0] MODE_INDEX = 8'h08;
	localparam logic [ADDR_W-1:0] FLAG_ADDR = 8'h04; // Index times four
	localparam logic [ADDR_W-1:0] MODE_ADDR = 8'h20; // Index times four

	// ======================================================================
	// Field layout and reset values
	localparam int MODE_W = 4;
	localparam int TIME_BASE_BIT = 3;
	localparam int FLAG_BIT = 2;
	localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
	localparam int COUNT_W = 8;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_TOP = 8'hff;
	localparam int SYS_PS_W = 11;
	localparam int WATCH_PS_W = 5;
	localparam int XTAL_DIV_W = 3;

	// ======================================================================
	// Timing
	localparam real CLOCK_PERIOD_NS = 50.0;
	localparam real WATCH_PERIOD_US = 244.14; // Eight crystal periods
	localparam int XTAL_PER_WATCH = 8;

	// ======================================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timebase_pkg

// [sim/tb.sv]
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the time-base counter
module tb;
	localparam logic [7:0] ma = timebase_pkg::MODE_ADDR;
	localparam logic [7:0] fa = timebase_pkg::FLAG_ADDR;
	localparam logic [1:0] ok = timebase_pkg::RESP_OKAY;
	localparam logic [1:0] err = timebase_pkg::RESP_SLVERR;
	localparam int xw = 160; // Watch period: 8 crystal periods of 20 cycles
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, watch_clk_pin = 1'b0;
	logic sys_prescaler_hold = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'he2ae;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, counter_a_overflow_pulse, counter_a_overflow_flag;
	logic time_base_select_bit, display_halt;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] counter_a_value;
	logic [1:0] wq[$];
	logic [33:0] rq[$];
	logic [33:0] rn;
	int mismatches = 0, n_compared = 0;
	int sys_p[8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};
	int tb_p[5] = '{32 * xw, 16 * xw, 8 * xw, 2 * xw, xw / 2};

	timebase_free_running_timer #(.INSTR_DIV(1))
		timebase_free_running_timer_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.watch_clk_pin, .sys_prescaler_hold, .counter_a_value,
		.counter_a_overflow_pulse, .counter_a_overflow_flag,
		.time_base_select_bit, .display_halt
	);

	// ======================================================================
	// Clocks: crystal edges never meet the bus clock edge
	always #25 aclk = ~aclk;
	always #500 watch_clk_pin = ~watch_clk_pin;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic check(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : check

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// ======================================================================
	// Bus tasks: the note goes on a queue, the monitor compares
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic aw_done = 1'b0;
		logic w_done = 1'b0;
		wq.push_back(r);
		seed = xs(seed);
		s_axi_awaddr <= a;
		s_axi_awprot <= seed[2:0];
		s_axi_wdata <= {seed[31:4], d[3:0]};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// Each channel lets go at its own handshake
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		rq.push_back({r, d});
		seed = xs(seed);
		s_axi_araddr <= a;
		s_axi_arprot <= seed[2:0];
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
	endtask : axi_read

	// Cycles between two changes of the count; the first gap is discarded
	task automatic measure(input string s, input int e);
		logic [7:0] v;
		int n;
		repeat (2) begin
			v = counter_a_value;
			n = 0;
			while (counter_a_value === v && n < 6000) begin
				@(posedge aclk);
				n++;
			end
		end
		check(s, e, n);
	endtask : measure

	task automatic pulse_gap(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (counter_a_overflow_pulse !== 1'b1 && n < 1000);
	endtask : pulse_gap

	// Responses are paired with the oldest note as each handshake lands
	always @(posedge aclk) begin
		if (aresetn && s_axi_bvalid && s_axi_bready)
			check("bresp", wq.pop_front(), s_axi_bresp);
		if (aresetn && s_axi_rvalid && s_axi_rready) begin
			rn = rq.pop_front();
			check("rdata", rn[31:0], s_axi_rdata);
			check("rresp", rn[33:32], s_axi_rresp);
		end
	end

	// Watchdog sized well above the roughly 28k cycles of the tests
	initial begin
		repeat (90000) @(posedge aclk);
		mismatches++;
		finish_test();
	end

	// ======================================================================
	// Main sequence
	initial begin
		int n;
		logic [7:0] v;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		s_axi_bready <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		check("mode bit", 0, time_base_select_bit);
		axi_read(ma, 0, ok);
		axi_read(fa, 0, ok);
		axi_read(8'h10, 0, err);
		axi_write(8'h10, 32'h8, err);
		check("mode bit", 0, time_base_select_bit);
		$display("test registers done");
		for (int c = 0; c < 8; c++) begin
			axi_write(ma, c, ok);
			measure("timer period", sys_p[c]);
		end
		$display("test timer codes done");
		pulse_gap(n);
		check("wrap count", 0, counter_a_value);
		check("flag pin", 1, counter_a_overflow_flag);
		axi_read(fa, 32'h4, ok);
		axi_write(fa, 32'h4, ok);
		axi_read(fa, 32'h4, ok);
		axi_write(fa, 32'h0, ok);
		axi_read(fa, 32'h0, ok);
		check("flag pin", 0, counter_a_overflow_flag);
		pulse_gap(n);
		pulse_gap(n);
		check("overflow gap", 512, n);
		// Hold is tested on the fastest tap so a leak shows at once
		sys_prescaler_hold <= 1'b1;
		repeat (4) @(posedge aclk);
		v = counter_a_value;
		repeat (40) @(posedge aclk);
		check("held count", v, counter_a_value);
		sys_prescaler_hold <= 1'b0;
		// Mid-run reset drops the pending flag, the count and the mode
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check("flag after reset", 0, counter_a_overflow_flag);
		check("count after reset", 0, counter_a_value);
		check("mode after reset", 0, time_base_select_bit);
		$display("test overflow done");
		// Ratio changes pass through the clear code, never mid time base
		for (int c = 0; c < 6; c++) begin
			axi_write(ma, 32'he + c % 2, ok);
			repeat (2) @(posedge aclk);
			check("halt", 1, display_halt);
			check("cleared", 0, counter_a_value);
			axi_write(ma, 32'h8 + c, ok);
			check("halt", 0, display_halt);
			check("mode bit", 1, time_base_select_bit);
			if (c < 5)
				measure("watch period", tb_p[c]);
			else
				repeat (400) @(posedge aclk);
		end
		check("unused code", 0, counter_a_value);
		$display("test time base done");
		finish_test();
	end
endmodule : tb

// [sim/timebase_checker.sv]
`timescale 1ns/1ps
// ==========================================================================
// Port-level checks of the counter block
module timebase_checker (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic [timebase_pkg::COUNT_W-1:0] counter_a_value, // Count
	input wire logic counter_a_overflow_pulse, // Wrap pulse
	input wire logic counter_a_overflow_flag, // Sticky flag
	input wire logic time_base_select_bit, // Mode bit 3
	input wire logic display_halt // Display off
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Count only steps up by one or returns to zero, never preloaded
	count_step_a: assert property (
		$changed(counter_a_value) |->
		counter_a_value == $past(counter_a_value) + 8'h01 ||
		counter_a_value == 8'h00) else $error("count jumped");
	// Pulse stands in the cycle after the all-ones to zero step
	wrap_pulse_a: assert property (counter_a_overflow_pulse |->
		$past(counter_a_value) == 8'hff &&
		counter_a_value == 8'h00) else $error("stray pulse");
	// Flag is set by the same edge that launches the pulse
	pulse_flag_a: assert property (counter_a_overflow_pulse |->
		counter_a_overflow_flag) else $error("flag not set");
	flag_rise_a: assert property (
		$rose(counter_a_overflow_flag) |->
		counter_a_overflow_pulse && counter_a_value == 8'h00)
		else $error("flag without wrap");
	// Flag drops only through a completed register write
	flag_clear_a: assert property (
		$fell(counter_a_overflow_flag) |->
		$rose(s_axi_bvalid)) else $error("flag lost");
	mode_write_a: assert property (
		$changed({time_base_select_bit, display_halt}) |->
		$rose(s_axi_bvalid)) else $error("mode moved alone");
	halt_mode_a: assert property (display_halt |->
		time_base_select_bit) else $error("halt outside time base");
	halt_clear_a: assert property (display_halt [*2] |->
		counter_a_value == 8'h00) else $error("count not held");
endmodule : timebase_checker

bind timebase_free_running_timer timebase_checker timebase_checker_inst (
	.aclk, .aresetn, .s_axi_bvalid, .counter_a_value,
	.counter_a_overflow_pulse, .counter_a_overflow_flag,
	.time_base_select_bit, .display_halt
);

// [verilog/prescaler_chain.sv]
`timescale 1ns/1ps
// ==========================================================================
// System and watch prescalers with one-cycle tap pulses
module prescaler_chain #(
	parameter int INSTR_DIV = 1
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, low
	input wire logic sys_hold, // Stops system prescaler
	input wire logic watch_clk_pin, // 32.768 kHz crystal level
	input wire logic watch_clear, // Holds watch prescaler at zero
	output logic [timebase_pkg::SYS_PS_W:1] sys_tap, // Period 2^k cycles
	output logic [timebase_pkg::WATCH_PS_W:0] watch_tap, // Period 2^k
	output logic watch_half_tick // Half watch period
);
	localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

	// ======================================================================
	// Parameter check
	generate
		if (INSTR_DIV < 1) begin : g_bad_div
			$error("INSTR_DIV must be at least one");
		end
	endgenerate

	logic [DIV_W-1:0] div_q;
	logic instr_en;
	logic [timebase_pkg::SYS_PS_W-1:0] sys_ps_q;
	logic sync1_q, sync2_q, sync3_q;
	logic xtal_edge;
	logic [timebase_pkg::XTAL_DIV_W-1:0] xdiv_q;
	logic watch_tick;
	logic [timebase_pkg::WATCH_PS_W-1:0] watch_ps_q;

	// Instruction-cycle enable from a divider
	assign instr_en = (INSTR_DIV == 1) ||
		(div_q == DIV_W'(INSTR_DIV - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || instr_en) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// System prescaler, frozen in low-power modes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_ps_q <= '0; // [R14]
		end else if (instr_en && !sys_hold) begin
			sys_ps_q <= sys_ps_q + 1'b1; // [R14]
		end
	end

	// Tap k pulses when the low k bits roll over
	genvar k;
	generate
		for (k = 1; k <= timebase_pkg::SYS_PS_W; k++) begin : g_sys
			assign sys_tap[k] = instr_en && !sys_hold && (&sys_ps_q[k-1:0]);
		end
	endgenerate

	// Crystal level crosses in; stages two and three feed the edge detector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= watch_clk_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	assign xtal_edge = sync2_q && !sync3_q;

	// Divide by eight, then five-bit watch prescaler
	assign watch_tick = xtal_edge && (&xdiv_q);
	assign watch_half_tick = !watch_clear && xtal_edge && (&xdiv_q[1:0]);
	always_ff @(posedge aclk) begin
		if (!aresetn || watch_clear) begin
			xdiv_q <= '0; // [R13]
			watch_ps_q <= '0; // [R13]
		end else if (xtal_edge) begin
			xdiv_q <= xdiv_q + 1'b1;
			if (watch_tick) begin
				watch_ps_q <= watch_ps_q + 1'b1; // [R13]
			end
		end
	end

	// Watch taps: k = 0 is one watch period
	assign watch_tap[0] = watch_tick && !watch_clear;
	generate
		for (k = 1; k <= timebase_pkg::WATCH_PS_W; k++) begin : g_watch
			assign watch_tap[k] = watch_tick && !watch_clear &&
				(&watch_ps_q[k-1:0]);
		end
	endgenerate

endmodule : prescaler_chain

// [verilog/timebase_free_running_timer.sv]
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
// Contract
// [R1] The counter is eight bits wide, free running, never preloaded.
// [R2] Reset clears the counter; each selected input pulse adds one.
// [R3] A pulse at all ones raises overflow and wraps to zero, every 256.
// [R4] Each overflow sets the overflow flag held in bit 2 of the flag word.
// [R5] Mode bit 3 at one feeds the counter from the watch prescaler.
// [R6] In time-base mode software can clear watch prescaler and counter.
// [R7] The mode register is four bits, write only, reset to zero.
// [R8] Bit 3 low: codes 0 to 7 pick 2048,1024,512,128,32,8,4,2 cycles.
// [R9] Bit 3 high: 32,16,8,2 watch periods, half, unused, then clear hold.
// [R10] The clear-hold code halts the display driver while it lasts.
// [R11] Software leaves the division ratio alone during time-base mode.
// [R12] A watch period is eight crystal periods; overflow is 256 inputs.
// [R13] The watch prescaler is five bits on crystal/8, reset and clearable.
// [R14] The system prescaler is eleven bits, reset, stopped on hold.
// [R15] The overflow flag stays set until software clears it or reset.
module timebase_free_running_timer #(
	parameter int INSTR_DIV = 1
) (
	input wire logic aclk, // System clock, 20 MHz
	input wire logic aresetn, // Synchronous reset, low
	input wire logic [timebase_pkg::ADDR_W-1:0] s_axi_awaddr, // Write addr
	input wire logic [2:0] s_axi_awprot, // Unused
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [timebase_pkg::ADDR_W-1:0] s_axi_araddr, // Read addr
	input wire logic [2:0] s_axi_arprot, // Unused
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic watch_clk_pin, // Crystal clock level, asynchronous
	input wire logic sys_prescaler_hold, // Watch or subactive mode
	output logic [timebase_pkg::COUNT_W-1:0] counter_a_value, // Count
	output logic counter_a_overflow_pulse, // One cycle per wrap
	output logic counter_a_overflow_flag, // Sticky request flag
	output logic time_base_select_bit, // Time-base mode active
	output logic display_halt // Forces display driver off
);

	// ======================================================================
	// Declarations
	logic aw_held_q;
	logic [timebase_pkg::ADDR_W-1:0] aw_addr_q;
	logic w_held_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [timebase_pkg::MODE_W-1:0] mode_q;
	logic [timebase_pkg::COUNT_W-1:0] count_q, count_d;
	logic flag_q, flag_d;
	logic ovf_q;
	logic [timebase_pkg::SYS_PS_W:1] sys_tap;
	logic [timebase_pkg::WATCH_PS_W:0] watch_tap;
	logic watch_half_tick, hold_clear;

	// ======================================================================
	// Parameter check
	generate
		if (timebase_pkg::COUNT_W != 8) begin : g_bad_width
			$error("Counter must be eight bits wide");
		end
	endgenerate

	// ======================================================================
	// Tap selection helpers

	// System tap index for a three-bit code
	function automatic logic [3:0] sys_shift(input logic [2:0] code);
		case (code)
			3'h0: sys_shift = 4'hb; // 2048 cycles
			3'h1: sys_shift = 4'ha; // 1024
			3'h2: sys_shift = 4'h9; // 512
			3'h3: sys_shift = 4'h7; // 128
			3'h4: sys_shift = 4'h5; // 32
			3'h5: sys_shift = 4'h3; // 8
			3'h6: sys_shift = 4'h2; // 4
			3'h7: sys_shift = 4'h1; // 2
			default: sys_shift = 4'hb;
		endcase
	endfunction : sys_shift

	// Watch tap index; 4'hf marks codes with no watch tap
	function automatic logic [3:0] watch_shift(input logic [2:0] code);
		case (code)
			3'h0: watch_shift = 4'h5; // 32 watch periods
			3'h1: watch_shift = 4'h4; // 16
			3'h2: watch_shift = 4'h3; // 8
			3'h3: watch_shift = 4'h1; // 2
			default: watch_shift = 4'hf;
		endcase
	endfunction : watch_shift

	// Aligned register decode shared by both channels
	function automatic logic is_reg(
		input logic [timebase_pkg::ADDR_W-1:0] addr,
		input logic [timebase_pkg::ADDR_W-1:0] reg_addr
	);
		is_reg = (addr[timebase_pkg::ADDR_W-1:2] ==
			reg_addr[timebase_pkg::ADDR_W-1:2]);
	endfunction : is_reg

	// ======================================================================
	// Prescalers
	prescaler_chain #(
		.INSTR_DIV(INSTR_DIV)
	) u_prescalers (
		.aclk(aclk),
		.aresetn(aresetn),
		.sys_hold(sys_prescaler_hold),
		.watch_clk_pin(watch_clk_pin),
		.watch_clear(hold_clear),
		.sys_tap(sys_tap),
		.watch_tap(watch_tap),
		.watch_half_tick(watch_half_tick)
	);

	// ======================================================================
	// AXI4-Lite write channel

	// Address and data land in either order; response waits for both
	wire wr_fire = aw_held_q && w_held_q;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_mode_hit = is_reg(aw_addr_q, timebase_pkg::MODE_ADDR);
	wire wr_flag_hit = is_reg(aw_addr_q, timebase_pkg::FLAG_ADDR);
	wire wr_mapped = wr_mode_hit || wr_flag_hit;
	wire wr_mode = wr_fire && wr_mode_hit && w_strb_q[0];
	wire wr_flag = wr_fire && wr_flag_hit && w_strb_q[0];
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Capture write address
	always_ff @(posedge aclk) begin
		if (!aresetn || wr_fire) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (aw_take) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
	end

	// Capture write data
	always_ff @(posedge aclk) begin
		if (!aresetn || wr_fire) begin
			w_held_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (w_take) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	// Write response; unmapped addresses answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= timebase_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? timebase_pkg::RESP_OKAY :
				timebase_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ======================================================================
	// AXI4-Lite read channel

	// Mode word is write only and reads back as zero
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_mode_hit = is_reg(s_axi_araddr, timebase_pkg::MODE_ADDR);
	wire rd_flag_hit = is_reg(s_axi_araddr, timebase_pkg::FLAG_ADDR);
	wire [31:0] rd_word = rd_flag_hit ?
		(32'h0000_0001 << timebase_pkg::FLAG_BIT) & {32{flag_q}} :
		32'h0000_0000;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Read data come from a register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= timebase_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= (rd_mode_hit || rd_flag_hit) ?
				timebase_pkg::RESP_OKAY : timebase_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ======================================================================
	// Mode register

	// Low byte lane only; upper bits of the word are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= timebase_pkg::MODE_RESET; // [R7]
		end else if (wr_mode) begin
			mode_q <= w_data_q[timebase_pkg::MODE_W-1:0]; // [R7]
		end
	end

	// ======================================================================
	// Input clock selection
	wire time_base = mode_q[timebase_pkg::TIME_BASE_BIT]; // [R5]
	wire [2:0] code = mode_q[2:0];
	wire [3:0] sys_idx = sys_shift(code);
	wire [3:0] watch_idx = watch_shift(code);
	// Codes 11x in time-base mode hold prescaler W and counter at zero
	assign hold_clear = time_base && (code[2:1] == 2'b11); // [R6]
	// System taps per code
	wire sys_sel = sys_tap[sys_idx]; // [R8]
	// Code 100 takes the half-period tap; 101 feeds nothing
	wire watch_sel = (code == 3'h4) ? watch_half_tick :
		(watch_idx == 4'hf) ? 1'b0 : watch_tap[watch_idx[2:0]]; // [R9]
	// Mode change mid-period shifts the next overflow; software avoids it
	wire in_tick = time_base ? watch_sel : sys_sel; // [R5] [R11] [R12]
	wire wrap = in_tick && (count_q == timebase_pkg::COUNT_TOP);

	// ======================================================================
	// Counter

	// No load path exists: only reset, clear-hold or increment
	always_comb begin
		count_d = count_q;
		if (hold_clear) begin
			count_d = timebase_pkg::COUNT_RESET; // [R6]
		end else if (in_tick) begin
			count_d = count_q + 1'b1; // [R1] [R2] [R3]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= timebase_pkg::COUNT_RESET; // [R2]
		end else begin
			count_q <= count_d;
		end
	end

	// ======================================================================
	// Overflow flag

	// Set beats a same-cycle software clear so no wrap is lost
	always_comb begin
		flag_d = flag_q;
		if (wr_flag && !w_data_q[timebase_pkg::FLAG_BIT]) begin
			flag_d = 1'b0; // [R15]
		end
		if (wrap) begin
			flag_d = 1'b1; // [R4]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0; // [R15]
			ovf_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
			ovf_q <= wrap; // [R3]
		end
	end

	// ======================================================================
	// Outputs
	assign counter_a_value = count_q;
	assign counter_a_overflow_pulse = ovf_q;
	assign counter_a_overflow_flag = flag_q;
	assign time_base_select_bit = time_base;
	// Display stays dark for as long as the clear code is held
	assign display_halt = hold_clear; // [R10]

	// Prot inputs carry nothing this slave uses
	wire unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_q[31:8]};

endmodule : timebase_free_running_timer
